/* File: irq_remote_params.svh */
// constants for the module/host interrupt and remote run/stop link
// assumes inclusion by the package and both ends
// How it works
// RQ1: host interrupt acts on rising edge only
// RQ2: edge starts the one configured interrupt task
// RQ3: rearm only after task end instruction
// RQ4: edges during busy flag are dropped
// RQ5: more than one interrupt task flags error
// RQ6: service call raises interrupt request to host
// RQ7: host maps requests to pointers by slot
// RQ8: lower pointer wins between two requests
// RQ9: separate remote run and halt calls
// RQ10: opposite remote request from another unit errors
// RQ11: remote run follows key switch, halt stops
// RQ12: no relays set: run without clearing
// RQ13: second relay only: clear outside latch range
// RQ14: first relay set: clear all memory
// RQ15: host reset drops remote, follows key switch
// RQ16: keep clear relays reset unless clearing wanted
// RQ17: busy flag set at launch, cleared at end
`ifndef IRQ_REMOTE_PARAMS_SVH
`define IRQ_REMOTE_PARAMS_SVH
`define TASK_COUNT 8
`define POINTER_COUNT 8
`define FIRST_POINTER 5'h10
`define SLOT_RESET 3'h0
`endif

/* File: irq_remote_pkg.sv */
// types for the module/host interrupt and remote run/stop link
// assumes irq_remote_params.svh in the include path
`include "irq_remote_params.svh"
package irq_remote_pkg;
    typedef enum logic [1:0] {key_run, key_stop, key_pause, key_step} key_type;
    typedef enum logic [1:0] {mode_run, mode_stop, mode_pause, mode_step} mode_type;
    typedef enum logic [1:0] {remote_none, remote_run, remote_halt} remote_type;
    typedef enum logic [1:0] {clear_none, clear_unlatched, clear_all} clear_type;
endpackage

/* File: irq_remote_if.sv */
// link between the communication module and the host controller
// assumes one shared clock and reset
`timescale 1ns/1ns
`default_nettype none
interface irq_remote_if;
    logic host_irq;
    logic module_irq;
    logic remote_run_req;
    logic remote_halt_req;
    logic remote_error;
    modport module_end(input host_irq, remote_error,
        output module_irq, remote_run_req, remote_halt_req);
    modport host_end(output host_irq, remote_error,
        input module_irq, remote_run_req, remote_halt_req);
endinterface
`default_nettype wire

/* File: comm_module.sv */
// communication module end: host interrupt task launch and calls to host
// assumes host drives link from same clock domain
`timescale 1ns/1ns
`default_nettype none
`include "irq_remote_params.svh"
module comm_module (
    input wire logic clock,
    input wire logic resetn,
    irq_remote_if.module_end link,
    input wire logic [`TASK_COUNT-1:0] task_irq_start,
    input wire logic task_end,
    input wire logic host_interrupt_call,
    input wire logic remote_run_call,
    input wire logic remote_halt_call,
    output logic task_launch,
    output logic [`TASK_COUNT-1:0] task_active,
    output logic irq_busy,
    output logic task_setting_error,
    output logic remote_error_seen
);
    import irq_remote_pkg::*;
    typedef struct packed {
        logic irq_prev;
        logic busy;
        logic launch;
        logic [`TASK_COUNT-1:0] active;
        logic cfg_error;
        logic host_irq;
        logic run_req;
        logic halt_req;
        logic rerr;
    } state_type;
    state_type r, next_r;
    // ****************
    // next state
    // ****************
    always_comb begin
        logic edge_seen;
        logic one_task;
        edge_seen = 1'b0;
        one_task = 1'b0;
        next_r = r;
        next_r.launch = 1'b0;
        next_r.irq_prev = link.host_irq;
        edge_seen = link.host_irq && !r.irq_prev; // [RQ1]
        one_task = (task_irq_start != '0) &&
            ((task_irq_start & (task_irq_start - 1'b1)) == '0);
        next_r.cfg_error = (task_irq_start != '0) && !one_task; // [RQ5]
        if (r.busy && task_end) begin
            next_r.busy = 1'b0; // [RQ3] [RQ17]
            next_r.active = '0;
        end else if (edge_seen && !r.busy && one_task) begin // [RQ2] [RQ4]
            next_r.busy = 1'b1; // [RQ17]
            next_r.launch = 1'b1;
            next_r.active = task_irq_start;
        end
        next_r.host_irq = host_interrupt_call; // [RQ6]
        next_r.run_req = remote_run_call && !remote_halt_call; // [RQ9]
        next_r.halt_req = remote_halt_call && !remote_run_call;
        next_r.rerr = link.remote_error;
    end
    // ****************
    // registers
    // ****************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign link.module_irq = r.host_irq;
    assign link.remote_run_req = r.run_req;
    assign link.remote_halt_req = r.halt_req;
    assign task_launch = r.launch;
    assign task_active = r.active;
    assign irq_busy = r.busy;
    assign task_setting_error = r.cfg_error;
    assign remote_error_seen = r.rerr;
endmodule
`default_nettype wire

/* File: host_cpu.sv */
// host controller end: interrupt pointer, remote mode and clearing
// assumes module end on same clock; slot order fixes pointer
`timescale 1ns/1ns
`default_nettype none
`include "irq_remote_params.svh"
module host_cpu (
    input wire logic clock,
    input wire logic resetn,
    irq_remote_if.host_end link,
    input wire logic irq_to_module,
    input wire logic [2:0] module_slot,
    input wire logic [`POINTER_COUNT-1:0] other_irq,
    input wire logic [1:0] key_switch,
    input wire logic other_remote_run,
    input wire logic other_remote_halt,
    input wire logic clear_all_memory_relay,
    input wire logic clear_unlatched_memory_relay,
    input wire logic host_reset,
    output logic irq_taken,
    output logic [4:0] irq_pointer,
    output logic [1:0] run_mode,
    output logic [1:0] clear_action,
    output logic clear_pulse
);
    import irq_remote_pkg::*;
    typedef struct packed {
        logic hirq;
        logic taken;
        logic [4:0] ptr;
        remote_type remote;
        logic rerr;
        mode_type mode;
        clear_type clr;
        logic clr_pulse;
    } state_type;
    state_type r, next_r;
    // ****************
    // next state
    // ****************
    always_comb begin
        logic [`POINTER_COUNT-1:0] reqs;
        logic found;
        reqs = other_irq;
        found = 1'b0;
        next_r = r;
        next_r.hirq = irq_to_module;
        next_r.taken = 1'b0;
        next_r.clr_pulse = 1'b0;
        reqs[module_slot] = reqs[module_slot] | link.module_irq; // [RQ7]
        for (int i = 0; i < `POINTER_COUNT; i++) begin
            if (reqs[i] && !found) begin // [RQ8]
                found = 1'b1;
                next_r.taken = 1'b1;
                next_r.ptr = `FIRST_POINTER + 5'(i);
            end
        end
        next_r.rerr = 1'b0;
        if ((link.remote_run_req && other_remote_halt) ||
            (link.remote_halt_req && other_remote_run)) begin
            next_r.rerr = 1'b1; // [RQ10]
        end else if (link.remote_run_req) begin
            next_r.remote = remote_run;
            next_r.clr_pulse = 1'b1;
            if (clear_all_memory_relay) begin
                next_r.clr = clear_all; // [RQ14]
            end else if (clear_unlatched_memory_relay) begin
                next_r.clr = clear_unlatched; // [RQ13]
            end else begin
                next_r.clr = clear_none; // [RQ12] [RQ16]
            end
        end else if (link.remote_halt_req) begin
            next_r.remote = remote_halt;
        end
        if (host_reset) begin
            next_r.remote = remote_none; // [RQ15]
            next_r.clr_pulse = 1'b0;
        end
        if (next_r.remote == remote_halt) begin
            next_r.mode = mode_stop; // [RQ11]
        end else begin
            next_r.mode = mode_type'(key_switch); // [RQ11] [RQ15]
        end
    end
    // ****************
    // registers
    // ****************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            r <= '{hirq: 1'b0, taken: 1'b0, ptr: `FIRST_POINTER, remote: remote_none,
                rerr: 1'b0, mode: mode_stop, clr: clear_none, clr_pulse: 1'b0};
        end else begin
            r <= next_r;
        end
    end
    assign link.host_irq = r.hirq;
    assign link.remote_error = r.rerr;
    assign irq_taken = r.taken;
    assign irq_pointer = r.ptr;
    assign run_mode = r.mode;
    assign clear_action = r.clr;
    assign clear_pulse = r.clr_pulse;
endmodule
`default_nettype wire

/* File: link_chk.sv */
// checker of the module/host link and the module interrupt flags
// assumes one clock; tb_top instances it beside the link
`timescale 1ns/1ns
`default_nettype none
module link_chk (
    input wire logic clock,
    input wire logic resetn,
    input wire logic host_irq,
    input wire logic module_irq,
    input wire logic remote_run_req,
    input wire logic remote_halt_req,
    input wire logic host_interrupt_call,
    input wire logic task_end,
    input wire logic task_launch,
    input wire logic irq_busy
);
    // ****
    // properties
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_edge; task_launch |-> $past(host_irq) && !$past(host_irq, 2); endproperty
    a_edge: assert property (p_edge) else $error("launch off edge");
    property p_pulse; task_launch |=> !task_launch; endproperty
    a_pulse: assert property (p_pulse) else $error("launch too long");
    property p_hold; irq_busy && !task_end |=> irq_busy; endproperty
    a_hold: assert property (p_hold) else $error("busy dropped");
    property p_set; task_launch |-> irq_busy && !$past(irq_busy); endproperty
    a_set: assert property (p_set) else $error("launch while busy");
    property p_rise; $rose(irq_busy) |-> task_launch; endproperty
    a_rise: assert property (p_rise) else $error("busy without launch");
    property p_end; irq_busy && task_end |=> !irq_busy && !task_launch; endproperty
    a_end: assert property (p_end) else $error("end not seen");
    property p_call; host_interrupt_call |=> module_irq; endproperty
    a_call: assert property (p_call) else $error("no host request");
    property p_excl; !(remote_run_req && remote_halt_req); endproperty
    a_excl: assert property (p_excl) else $error("run and halt");
    c_launch: cover property (task_launch);
    c_end: cover property (irq_busy && task_end);
    c_halt: cover property (remote_halt_req);
endmodule
`default_nettype wire

/* File: tb_top.sv */
// bench joining both ends through the link, random and corner cases
// assumes the package, link, both ends and link_chk compiled before
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import irq_remote_pkg::*;
    logic clock, resetn, task_end, host_interrupt_call, remote_run_call, remote_halt_call;
    logic irq_to_module, other_remote_run, other_remote_halt, host_reset;
    logic clear_all_memory_relay, clear_unlatched_memory_relay;
    logic task_launch, irq_busy, task_setting_error, remote_error_seen, irq_taken, clear_pulse;
    logic [7:0] task_irq_start, other_irq, task_active;
    logic [2:0] module_slot;
    logic [1:0] key_switch, run_mode, clear_action;
    logic [4:0] irq_pointer;
    logic [15:0] lfsr = 16'hCFAD;
    int err_total = 0, n_compared = 0, i;
    irq_remote_if link();
    comm_module i_comm_module(.clock, .resetn, .link(link), .task_irq_start, .task_end,
        .host_interrupt_call, .remote_run_call, .remote_halt_call, .task_launch,
        .task_active, .irq_busy, .task_setting_error, .remote_error_seen);
    host_cpu i_host_cpu(.clock, .resetn, .link(link), .irq_to_module, .module_slot,
        .other_irq, .key_switch, .other_remote_run, .other_remote_halt,
        .clear_all_memory_relay, .clear_unlatched_memory_relay, .host_reset, .irq_taken,
        .irq_pointer, .run_mode, .clear_action, .clear_pulse);
    link_chk i_link_chk(.clock, .resetn, .host_irq(link.host_irq), .module_irq(link.module_irq),
        .remote_run_req(link.remote_run_req), .remote_halt_req(link.remote_halt_req),
        .host_interrupt_call, .task_end, .task_launch, .irq_busy);
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [7:0] exp_clear(input logic a, input logic u);
        return a ? 8'h02 : (u ? 8'h01 : 8'h00);
    endfunction
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task ticks(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task close_out;
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        clock = 0;
        forever #4 clock = ~clock;
    end
    initial begin
        {resetn, task_end, host_interrupt_call, remote_run_call, remote_halt_call} = '0;
        {irq_to_module, other_remote_run, other_remote_halt, host_reset} = '0;
        {clear_all_memory_relay, clear_unlatched_memory_relay, key_switch} = '0;
        {task_irq_start, other_irq, module_slot} = '0;
        repeat (16) @(posedge clock);
        resetn <= 1;
        for (int k = 0; k < 3; k++) begin
            lfsr = nx(lfsr);
            @(posedge clock) task_irq_start <= 8'h01 << lfsr[2:0];
            irq_to_module <= 1;
            for (i = 0; i < 12 && task_launch !== 1'b1; i++) ticks(1);
            if (i == 12) begin
                err_total++;
                close_out();
            end
            chk(task_active, task_irq_start);
            @(posedge clock) irq_to_module <= 0;
            @(posedge clock) irq_to_module <= 1;
            ticks(2);
            chk(task_launch, 8'h00);
            chk(irq_busy, 8'h01);
            @(posedge clock) task_end <= 1;
            @(posedge clock) task_end <= 0;
            irq_to_module <= 0;
            ticks(2);
            chk(irq_busy, 8'h00);
            chk(task_active, 8'h00);
        end
        @(posedge clock) task_irq_start <= 8'h81;
        irq_to_module <= 1;
        ticks(4);
        chk(task_setting_error, 8'h01);
        chk(irq_busy, 8'h00);
        $display("interrupt test done");
        lfsr = nx(lfsr);
        @(posedge clock) module_slot <= lfsr[2:0] | 3'h1;
        host_interrupt_call <= 1;
        ticks(3);
        chk(link.module_irq, 8'h01);
        chk(irq_taken, 8'h01);
        chk(irq_pointer, 8'h10 + module_slot);
        @(posedge clock) other_irq <= 8'h01;
        ticks(2);
        chk(irq_pointer, 8'h10);
        @(posedge clock) {host_interrupt_call, other_irq} <= '0;
        for (int r = 0; r < 4; r++) begin
            @(posedge clock) key_switch <= r[1:0];
            {clear_all_memory_relay, clear_unlatched_memory_relay} <= r[1:0];
            {remote_run_call, remote_halt_call} <= 2'h2;
            ticks(3);
            chk(run_mode, r[1:0]);
            chk(clear_action, exp_clear(r[1], r[0]));
            chk(clear_pulse, 8'h01);
            chk(irq_taken, 8'h00);
            @(posedge clock) {remote_run_call, remote_halt_call} <= 2'h1;
            ticks(3);
            chk(run_mode, 8'h01);
        end
        @(posedge clock) {remote_run_call, remote_halt_call, host_reset} <= 3'h1;
        key_switch <= 2'h2;
        @(posedge clock) host_reset <= 0;
        ticks(3);
        chk(run_mode, 8'h02);
        @(posedge clock) other_remote_run <= 1;
        remote_halt_call <= 1;
        ticks(4);
        chk(remote_error_seen, 8'h01);
        chk(run_mode, 8'h02);
        @(posedge clock) other_remote_run <= 0;
        remote_halt_call <= 0;
        ticks(3);
        chk(remote_error_seen, 8'h00);
        $display("remote test done");
        close_out();
    end
endmodule
`default_nettype wire
